// ===== design/timer_pwm_unit.sv
/*
 * Timer and PWM unit: AXI4-Lite register slave, flags with read-then-write-zero clearing,
 * coherent byte buffers for modulus and channel values, and per-channel capture, compare
 * and PWM logic.
 * Assumes REF_CLK is the counting clock and all channel pin inputs are synchronous to it.
 */
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ns
`include "timer_pwm_defs.svh"

module timer_pwm_unit (
    input  wire logic               REF_CLK,
    input  wire logic               RST_N,
    input  wire logic [7:0]         AXI_AWADDR,
    input  wire logic               AXI_AWVALID,
    output logic                    AXI_AWREADY,
    input  wire logic [31:0]        AXI_WDATA,
    input  wire logic [3:0]         AXI_WSTRB,
    input  wire logic               AXI_WVALID,
    output logic                    AXI_WREADY,
    output logic [1:0]              AXI_BRESP,
    output logic                    AXI_BVALID,
    input  wire logic               AXI_BREADY,
    input  wire logic [7:0]         AXI_ARADDR,
    input  wire logic               AXI_ARVALID,
    output logic                    AXI_ARREADY,
    output logic [31:0]             AXI_RDATA,
    output logic [1:0]              AXI_RRESP,
    output logic                    AXI_RVALID,
    input  wire logic               AXI_RREADY,
    input  wire logic [`NUM_CH-1:0] CH_IN,
    output logic [`NUM_CH-1:0]      CH_OUT,
    output logic [`NUM_CH-1:0]      CH_OE_N,
    output logic [`NUM_CH-1:0]      IRQ_CH,
    output logic                    IRQ_OVF
);

    timer_pwm_pkg::timer_state_type q;
    timer_pwm_pkg::timer_state_type d;
    logic [15:0]                    cnt;
    logic                           cnt_down;
    logic                           cnt_tick;
    logic                           cnt_ovf;

    // Channel mode from center select and the two mode bits
    function automatic timer_pwm_pkg::chan_mode_type chan_mode(
        input logic center,
        input logic msb,
        input logic msa
    );
        if (center) begin
            chan_mode = timer_pwm_pkg::MODE_CENTER_PWM;
        end else if (msb) begin
            chan_mode = timer_pwm_pkg::MODE_EDGE_PWM;
        end else if (msa) begin
            chan_mode = timer_pwm_pkg::MODE_COMPARE;
        end else begin
            chan_mode = timer_pwm_pkg::MODE_CAPTURE;
        end
    endfunction : chan_mode

    // Channel slot hit: returns 1 when addr is one of the three word-aligned registers in channel n's slot
    function automatic logic chan_hit(input logic [7:0] addr, input int n);
        chan_hit = (addr[7:4] == `CH_SLOT0 + 4'(n)) && (addr[3:2] != 2'h3) && (addr[1:0] == 2'h0);
    endfunction : chan_hit

    // Timer counter
    timer_counter counter_i (
        .clk     (REF_CLK),
        .rst_n   (RST_N),
        .run     (q.run),
        .center  (q.center),
        .modulus (q.modulus),
        .clear   (q.cnt_clear),
        .count   (cnt),
        .down    (cnt_down),
        .tick    (cnt_tick),
        .ovf     (cnt_ovf)
    );

    // Bus handshakes, register reads and writes, flags, buffers and channel pins
    always_comb begin
        logic                         do_wr;
        logic                         wr_en;
        logic                         rd_en;
        logic                         hit;
        logic [7:0]                   rd;
        logic                         match;
        logic                         evt;
        logic                         rise;
        logic                         fall;
        logic                         act;
        timer_pwm_pkg::chan_mode_type mode;
        do_wr = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        hit = 1'b0;
        rd = `BYTE_ZERO;
        match = 1'b0;
        evt = 1'b0;
        rise = 1'b0;
        fall = 1'b0;
        act = 1'b0;
        mode = timer_pwm_pkg::MODE_CAPTURE;
        d = q;
        d.cnt_clear = 1'b0;

        // Write address and data are taken independently
        if (AXI_AWVALID && q.awready) begin
            d.aw_have = 1'b1;
            d.awaddr = AXI_AWADDR;
        end
        if (AXI_WVALID && q.wready) begin
            d.w_have = 1'b1;
            d.wdata = AXI_WDATA[7:0];
            d.wlane0 = AXI_WSTRB[0];
        end
        if (q.bvalid && AXI_BREADY) begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid && AXI_RREADY) begin
            d.rvalid = 1'b0;
        end

        // Execute the write once both halves are held
        if (q.aw_have && q.w_have && !q.bvalid) begin
            do_wr = 1'b1;
            wr_en = q.wlane0;
            d.aw_have = 1'b0;
            d.w_have = 1'b0;
            d.bvalid = 1'b1;
        end
        rd_en = AXI_ARVALID && q.arready;

        // Timer-wide registers
        hit = 1'b0;
        if (do_wr) begin
            unique case (q.awaddr)
                `OFF_TSC: begin
                    hit = 1'b1;
                    if (wr_en) begin
                        if (q.ovf_armed && !q.wdata[`TSC_FLAG]) begin
                            d.ovf_flag = 1'b0;
                        end
                        d.ovf_armed = 1'b0;
                        d.ovf_en = q.wdata[`TSC_IEN];
                        d.center = q.wdata[`TSC_CPWM];
                        d.run = q.wdata[`TSC_RUN];
                        d.mgot_hi = 1'b0;
                        d.mgot_lo = 1'b0;
                    end
                end
                `OFF_CNT_HI, `OFF_CNT_LO: begin
                    hit = 1'b1;
                    d.cnt_clear = wr_en;
                end
                `OFF_MOD_HI: begin
                    hit = 1'b1;
                    if (wr_en) begin
                        d.mbuf_hi = q.wdata;
                        d.mgot_hi = 1'b1;
                    end
                end
                `OFF_MOD_LO: begin
                    hit = 1'b1;
                    if (wr_en) begin
                        d.mbuf_lo = q.wdata;
                        d.mgot_lo = 1'b1;
                    end
                end
                default: hit = 1'b0;
            endcase
        end

        // Reads of timer-wide registers; a read of a set flag arms its clear
        if (rd_en) begin
            d.rvalid = 1'b1;
            d.rresp = `RESP_OKAY;
            unique case (AXI_ARADDR)
                `OFF_TSC: begin
                    rd = {q.ovf_flag, q.ovf_en, q.center, 4'h0, q.run};
                    if (q.ovf_flag) begin
                        d.ovf_armed = 1'b1;
                    end
                end
                `OFF_CNT_HI: rd = cnt[15:8];
                `OFF_CNT_LO: rd = cnt[7:0];
                `OFF_MOD_HI: rd = q.modulus[15:8];
                `OFF_MOD_LO: rd = q.modulus[7:0];
                default: d.rresp = `RESP_SLVERR;
            endcase
        end

        // Modulus moves at overflow once both bytes are in, or at once while stopped
        if (q.mgot_hi && q.mgot_lo && (cnt_ovf || !q.run)) begin
            d.modulus = {q.mbuf_hi, q.mbuf_lo};
            d.mgot_hi = 1'b0;
            d.mgot_lo = 1'b0;
        end

        // Overflow event wins over a clear in the same cycle
        if (cnt_ovf) begin
            d.ovf_flag = 1'b1;
            d.ovf_armed = 1'b0;
        end

        // Per-channel registers and timer functions
        for (int n = 0; n < `NUM_CH; n++) begin
            mode = chan_mode(q.center, q.ch[n].msb, q.ch[n].msa);

            // Channel register writes
            if (do_wr && chan_hit(q.awaddr, n)) begin
                hit = 1'b1;
                if (wr_en) begin
                    unique case (q.awaddr[3:2])
                        `CH_SUB_CSC: begin
                            if (q.ch[n].armed && !q.wdata[`CSC_FLAG]) begin
                                d.ch[n].flag = 1'b0;
                            end
                            d.ch[n].armed = 1'b0;
                            d.ch[n].irq_en = q.wdata[`CSC_IEN];
                            d.ch[n].msb = q.wdata[`CSC_MSB];
                            d.ch[n].msa = q.wdata[`CSC_MSA];
                            d.ch[n].els = q.wdata[`CSC_ELSB:`CSC_ELSA];
                            d.ch[n].got_hi = 1'b0;
                            d.ch[n].got_lo = 1'b0;
                        end
                        `CH_SUB_VHI: begin
                            d.ch[n].buf_hi = q.wdata;
                            d.ch[n].got_hi = 1'b1;
                        end
                        default: begin
                            d.ch[n].buf_lo = q.wdata;
                            d.ch[n].got_lo = 1'b1;
                        end
                    endcase
                end
            end

            // Channel register reads
            if (rd_en && chan_hit(AXI_ARADDR, n)) begin
                d.rresp = `RESP_OKAY;
                unique case (AXI_ARADDR[3:2])
                    `CH_SUB_CSC: begin
                        rd = {q.ch[n].flag, q.ch[n].irq_en, q.ch[n].msb, q.ch[n].msa, q.ch[n].els, 2'h0};
                        if (q.ch[n].flag) begin
                            d.ch[n].armed = 1'b1;
                        end
                    end
                    `CH_SUB_VHI: rd = q.ch[n].value[15:8];
                    default: rd = q.ch[n].value[7:0];
                endcase
            end

            // Value buffer transfer: PWM waits for overflow while running, others and stopped PWM move at once
            if (q.ch[n].got_hi && q.ch[n].got_lo) begin
                if (mode == timer_pwm_pkg::MODE_CAPTURE || mode == timer_pwm_pkg::MODE_COMPARE
                    || cnt_ovf || !q.run) begin
                    d.ch[n].value = {q.ch[n].buf_hi, q.ch[n].buf_lo};
                    d.ch[n].got_hi = 1'b0;
                    d.ch[n].got_lo = 1'b0;
                end
            end

            // Edge detection on the pin and counter match
            d.ch[n].pin_prev = CH_IN[n];
            rise = CH_IN[n] && !q.ch[n].pin_prev;
            fall = !CH_IN[n] && q.ch[n].pin_prev;
            match = cnt_tick && (cnt == q.ch[n].value);
            act = !q.ch[n].els[0];
            evt = 1'b0;

            // Mode behaviour
            unique case (mode)
                timer_pwm_pkg::MODE_CAPTURE: begin
                    evt = (q.ch[n].els[0] && rise) || (q.ch[n].els[1] && fall);
                    if (evt) begin
                        d.ch[n].value = cnt;
                    end
                end
                timer_pwm_pkg::MODE_COMPARE: begin
                    evt = match;
                    if (match) begin
                        unique case (q.ch[n].els)
                            2'h1: d.ch[n].out = !q.ch[n].out;
                            2'h2: d.ch[n].out = 1'b0;
                            2'h3: d.ch[n].out = 1'b1;
                            default: d.ch[n].out = q.ch[n].out;
                        endcase
                    end
                end
                timer_pwm_pkg::MODE_EDGE_PWM: begin
                    evt = match;
                    if (match) begin
                        d.ch[n].out = !act;
                    end else if (cnt_tick && cnt == `CNT_ZERO) begin
                        d.ch[n].out = act;
                    end
                end
                timer_pwm_pkg::MODE_CENTER_PWM: begin
                    evt = match;
                    if (match) begin
                        d.ch[n].out = cnt_down ? act : !act;
                    end
                end
            endcase

            // Pin released in capture mode and when both edge/level bits are clear
            d.ch[n].oe_n = (q.ch[n].els == 2'h0) || (mode == timer_pwm_pkg::MODE_CAPTURE);

            // Event wins over a pending clear
            if (evt) begin
                d.ch[n].flag = 1'b1;
                d.ch[n].armed = 1'b0;
            end
            d.ch[n].irq = d.ch[n].flag && d.ch[n].irq_en;
        end

        // Bus answers and ready terms
        if (do_wr) begin
            d.bresp = hit ? `RESP_OKAY : `RESP_SLVERR;
        end
        if (rd_en) begin
            d.rdata = rd;
        end
        d.irq_ovf = d.ovf_flag && d.ovf_en;
        d.awready = !d.aw_have && !d.bvalid;
        d.wready = !d.w_have && !d.bvalid;
        d.arready = !d.rvalid;
    end

    // State register; reset clears flags, enables, buffers and pairing state
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign AXI_AWREADY = q.awready;
    assign AXI_WREADY = q.wready;
    assign AXI_BVALID = q.bvalid;
    assign AXI_BRESP = q.bresp;
    assign AXI_ARREADY = q.arready;
    assign AXI_RVALID = q.rvalid;
    assign AXI_RRESP = q.rresp;
    assign AXI_RDATA = {24'h000000, q.rdata};
    assign IRQ_OVF = q.irq_ovf;

    // Per-channel outputs
    always_comb begin
        for (int n = 0; n < `NUM_CH; n++) begin
            CH_OUT[n] = q.ch[n].out;
            CH_OE_N[n] = q.ch[n].oe_n;
            IRQ_CH[n] = q.ch[n].irq;
        end
    end

endmodule : timer_pwm_unit

// ===== design/timer_pwm_defs.svh
/*
 * Register offsets, field positions, reset values and bus codes of the timer and PWM unit.
 * Assumes byte-wide registers, each in the low bits of one aligned 32-bit word.
 */
`ifndef TIMER_PWM_DEFS_SVH
`define TIMER_PWM_DEFS_SVH

// Channel count and address width
`define NUM_CH        2
`define ADDR_W        8

// Timer-wide register byte addresses
`define OFF_TSC       8'h00
`define OFF_CNT_HI    8'h04
`define OFF_CNT_LO    8'h08
`define OFF_MOD_HI    8'h0c
`define OFF_MOD_LO    8'h10

// Channel n sits in the 16-byte slot ADDR[7:4] = CH_SLOT0 + n
`define CH_SLOT0      4'h2
`define CH_SUB_CSC    2'h0
`define CH_SUB_VHI    2'h1
`define CH_SUB_VLO    2'h2

// Timer status/control fields
`define TSC_FLAG      7
`define TSC_IEN       6
`define TSC_CPWM      5
`define TSC_RUN       0

// Channel status/control fields
`define CSC_FLAG      7
`define CSC_IEN       6
`define CSC_MSB       5
`define CSC_MSA       4
`define CSC_ELSB      3
`define CSC_ELSA      2

// Counter values and reset values
`define CNT_ZERO      16'h0000
`define CNT_FULL      16'hffff
`define BYTE_ZERO     8'h00

// Bus response codes
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// ===== design/timer_pwm_pkg.sv
/*
 * Types shared by the timer counter and the register and channel block.
 * Assumes timer_pwm_defs.svh on the include path.
 */
`include "timer_pwm_defs.svh"

package timer_pwm_pkg;

    typedef enum logic [1:0] {
        MODE_CAPTURE,
        MODE_COMPARE,
        MODE_EDGE_PWM,
        MODE_CENTER_PWM
    } chan_mode_type;

    typedef struct packed {
        logic [15:0] count;
        logic        down;
        logic        tick;
        logic        ovf;
    } counter_state_type;

    typedef struct packed {
        logic        flag;
        logic        armed;
        logic        irq_en;
        logic        msb;
        logic        msa;
        logic [1:0]  els;
        logic [15:0] value;
        logic [7:0]  buf_hi;
        logic [7:0]  buf_lo;
        logic        got_hi;
        logic        got_lo;
        logic        pin_prev;
        logic        out;
        logic        oe_n;
        logic        irq;
    } chan_state_type;

    typedef struct packed {
        chan_state_type [`NUM_CH-1:0] ch;
        logic        ovf_flag;
        logic        ovf_armed;
        logic        ovf_en;
        logic        center;
        logic        run;
        logic [15:0] modulus;
        logic [7:0]  mbuf_hi;
        logic [7:0]  mbuf_lo;
        logic        mgot_hi;
        logic        mgot_lo;
        logic        cnt_clear;
        logic        irq_ovf;
        logic        aw_have;
        logic [7:0]  awaddr;
        logic        w_have;
        logic [7:0]  wdata;
        logic        wlane0;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [7:0]  rdata;
        logic [1:0]  rresp;
    } timer_state_type;

endpackage : timer_pwm_pkg

// ===== design/timer_counter.sv
/*
 * 16-bit timer counter: up counting or up/down counting with a modulus limit.
 * Assumes run, center, modulus and clear come from registers in the same clock domain.
 */
`timescale 1ns/1ns
`include "timer_pwm_defs.svh"

module timer_counter (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        run,
    input  wire logic        center,
    input  wire logic [15:0] modulus,
    input  wire logic        clear,
    output logic [15:0]      count,
    output logic             down,
    output logic             tick,
    output logic             ovf
);

    timer_pwm_pkg::counter_state_type q;
    timer_pwm_pkg::counter_state_type d;
    logic [15:0]                      top;

    // Modulus of all zeros or all ones leaves the counter free running
    assign top = (modulus == `CNT_ZERO || modulus == `CNT_FULL) ? `CNT_FULL : modulus;

    // Next count, direction and overflow pulse
    always_comb begin
        d = q;
        d.tick = 1'b0;
        d.ovf = 1'b0;
        if (clear) begin
            d.count = `CNT_ZERO;
            d.down = 1'b0;
        end else if (run) begin
            d.tick = 1'b1;
            if (!center) begin
                if (q.count >= top) begin
                    d.count = `CNT_ZERO;
                    d.ovf = 1'b1;
                end else begin
                    d.count = q.count + 16'h0001;
                end
            end else if (!q.down) begin
                if (q.count >= top) begin
                    d.down = (top != `CNT_ZERO);
                    d.ovf = 1'b1;
                    d.count = (top == `CNT_ZERO) ? `CNT_ZERO : q.count - 16'h0001;
                end else begin
                    d.count = q.count + 16'h0001;
                end
            end else if (q.count == `CNT_ZERO) begin
                d.down = 1'b0;
                d.count = 16'h0001;
            end else begin
                d.count = q.count - 16'h0001;
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign count = q.count;
    assign down = q.down;
    assign tick = q.tick;
    assign ovf = q.ovf;

endmodule : timer_counter

// ===== verification/timer_pwm_unit_monitor.sv
/* Checker for timer_pwm_unit: channel 0 pin, interrupts, write completion.
   Assumes the master offers write address and data in the same cycle. */
`timescale 1ns/1ns
module timer_pwm_unit_monitor (
    input wire logic        REF_CLK,
    input wire logic        RST_N,
    input wire logic [7:0]  AXI_AWADDR,
    input wire logic        AXI_AWVALID,
    input wire logic        AXI_AWREADY,
    input wire logic [31:0] AXI_WDATA,
    input wire logic        AXI_BVALID,
    input wire logic        AXI_BREADY,
    input wire logic [1:0]  CH_OE_N,
    input wire logic [1:0]  IRQ_CH,
    input wire logic        IRQ_OVF
);
    logic       up_q;
    logic       busy_q;
    logic [4:0] csc_q;
    logic       cen_q;
    wire        idle = up_q && !busy_q;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    // Shadow of channel 0 control bits 6:2 and center select, and write-in-progress tracking
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            up_q <= 1'b0;
            busy_q <= 1'b0;
            csc_q <= 5'h00;
            cen_q <= 1'b0;
        end else begin
            up_q <= 1'b1;
            if (AXI_AWVALID && AXI_AWREADY) begin
                busy_q <= 1'b1;
                if (AXI_AWADDR == 8'h20) csc_q <= AXI_WDATA[6:2];
                if (AXI_AWADDR == 8'h00) cen_q <= AXI_WDATA[5];
            end else if (AXI_BVALID && AXI_BREADY) busy_q <= 1'b0;
        end
    end
    sequence s_wtake; AXI_AWVALID && AXI_AWREADY; endsequence
    property p_irq_off; idle && !csc_q[4] |-> !IRQ_CH[0]; endproperty
    property p_pin_free; idle && csc_q[1:0] == 2'b00 |-> CH_OE_N[0]; endproperty
    property p_cap_free; idle && !cen_q && csc_q[3:2] == 2'b00 |-> CH_OE_N[0]; endproperty
    property p_cmp_drive; idle && csc_q[3:2] == 2'b01 && csc_q[1:0] != 2'b00 |-> !CH_OE_N[0]; endproperty
    property p_pwm_drive; idle && csc_q[3] && csc_q[1:0] != 2'b00 |-> !CH_OE_N[0]; endproperty
    property p_ch_clr; $fell(IRQ_CH[0]) |-> AXI_BVALID; endproperty
    property p_ovf_clr; $fell(IRQ_OVF) |-> AXI_BVALID; endproperty
    property p_wdone; s_wtake |-> ##[2:8] AXI_BVALID; endproperty
    a_irq_off: assert property (p_irq_off) else $error("channel irq while disabled");
    a_pin_free: assert property (p_pin_free) else $error("pin driven with edge bits 00");
    a_cap_free: assert property (p_cap_free) else $error("capture pin driven");
    a_cmp_drive: assert property (p_cmp_drive) else $error("compare pin not driven");
    a_pwm_drive: assert property (p_pwm_drive) else $error("pwm pin not driven");
    a_ch_clr: assert property (p_ch_clr) else $error("channel irq fell without write");
    a_ovf_clr: assert property (p_ovf_clr) else $error("overflow irq fell without write");
    a_wdone: assert property (p_wdone) else $error("write never answered");
endmodule : timer_pwm_unit_monitor
bind timer_pwm_unit timer_pwm_unit_monitor timer_pwm_unit_monitor_i (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .AXI_AWADDR(AXI_AWADDR), .AXI_AWVALID(AXI_AWVALID), .AXI_AWREADY(AXI_AWREADY), .AXI_WDATA(AXI_WDATA),
    .AXI_BVALID(AXI_BVALID), .AXI_BREADY(AXI_BREADY), .CH_OE_N(CH_OE_N), .IRQ_CH(IRQ_CH), .IRQ_OVF(IRQ_OVF));

// ===== verification/ch_pin_model.sv
/* External signals on the channel pins.
   Assumes the pins are sampled on the same clock. */
`timescale 1ns/1ns
module ch_pin_model (
    input wire logic  clk,
    output logic [1:0] pins
);
    initial pins = 2'b00;
    // Change pin levels just after a rising edge
    task automatic drive(input logic [1:0] v);
        @(posedge clk);
        pins <= v;
    endtask : drive
endmodule : ch_pin_model

// ===== verification/timer_pwm_unit_tb_top.sv
/* Register-level tests of timer_pwm_unit over AXI4-Lite.
   Assumes the map and field positions of timer_pwm_defs.svh. */
`timescale 1ns/1ns
`include "timer_pwm_defs.svh"
module timer_pwm_unit_tb_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq_ovf;
    logic [1:0]  bresp, rresp, ch_in, ch_out, ch_oe_n, irq_ch, r;
    logic [31:0] rdata, hi;
    logic [7:0]  d;
    int          err_total = 0, checks = 0, cyc = 0, i;
    always #5 clk = ~clk;
    timer_pwm_unit timer_pwm_unit_i (.REF_CLK(clk), .RST_N(rst_n), .AXI_AWADDR(awaddr), .AXI_AWVALID(awvalid),
        .AXI_AWREADY(awready), .AXI_WDATA(wdata), .AXI_WSTRB(4'h1), .AXI_WVALID(wvalid), .AXI_WREADY(wready),
        .AXI_BRESP(bresp), .AXI_BVALID(bvalid), .AXI_BREADY(bready), .AXI_ARADDR(araddr), .AXI_ARVALID(arvalid),
        .AXI_ARREADY(arready), .AXI_RDATA(rdata), .AXI_RRESP(rresp), .AXI_RVALID(rvalid), .AXI_RREADY(rready),
        .CH_IN(ch_in), .CH_OUT(ch_out), .CH_OE_N(ch_oe_n), .IRQ_CH(irq_ch), .IRQ_OVF(irq_ovf));
    ch_pin_model ch_pin_model_i (.clk(clk), .pins(ch_in));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test;
        if (err_total == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic done, ta, tw;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            done = bvalid;
            r = bresp;
            ta = awvalid && awready;
            tw = wvalid && wready;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (done) bready <= 1'b0;
        end while (!done);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic done, ta;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk);
            done = rvalid;
            d = rdata[7:0];
            r = rresp;
            ta = arvalid && arready;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            if (done) rready <= 1'b0;
        end while (!done);
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        chk({24'h0, d}, {24'h0, exp});
    endtask : rc
    task automatic wait_irq(input int ovf);
        for (i = 0; i < 300 && (ovf ? irq_ovf : irq_ch[0]) !== 1'b1; i++) @(negedge clk);
    endtask : wait_irq
    // Count cycles with channel 0 pin high over a window
    task automatic pwm_high(input int len);
        hi = 32'h0;
        repeat (len) begin
            @(negedge clk);
            hi = hi + ch_out[0];
        end
    endtask : pwm_high
    // Cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            end_of_test;
        end
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rc(8'h20, 8'h00);
        rd(8'hfc);
        chk(r, `RESP_SLVERR);
        wr(8'hfc, 8'h00);
        chk(r, `RESP_SLVERR);
        wr(8'h20, 8'h44);
        wr(8'h30, 8'h08);
        ch_pin_model_i.drive(2'b01);
        wait_irq(0);
        chk(irq_ch, 2'b01);
        chk(ch_oe_n, 2'b11);
        rc(8'h20, 8'hc4);
        wr(8'h20, 8'hc4);
        rc(8'h20, 8'hc4);
        ch_pin_model_i.drive(2'b10);
        ch_pin_model_i.drive(2'b11);
        repeat (3) @(posedge clk);
        rc(8'h30, 8'h08);
        wr(8'h20, 8'h44);
        rc(8'h20, 8'hc4);
        wr(8'h20, 8'h44);
        rc(8'h20, 8'h44);
        chk(irq_ch[0], 1'b0);
        ch_pin_model_i.drive(2'b00);
        repeat (3) @(posedge clk);
        rc(8'h30, 8'h88);
        wr(8'h24, 8'h00);
        wr(8'h28, 8'h40);
        wr(8'h20, 8'h54);
        wr(8'h24, 8'h00);
        wr(8'h20, 8'h54);
        wr(8'h28, 8'h50);
        rc(8'h28, 8'h40);
        wr(8'h24, 8'h00);
        rc(8'h28, 8'h50);
        chk(ch_oe_n[0], 1'b0);
        wr(8'h00, 8'h01);
        wait_irq(0);
        rc(8'h20, 8'hd4);
        wr(8'h00, 8'h00);
        wr(8'h0c, 8'h00);
        wr(8'h00, 8'h00);
        wr(8'h10, 8'h20);
        rc(8'h10, 8'h00);
        wr(8'h0c, 8'h00);
        rc(8'h10, 8'h20);
        wr(8'h08, 8'h77);
        rc(8'h08, 8'h00);
        wr(8'h00, 8'h41);
        wait_irq(1);
        chk(irq_ovf, 1'b1);
        rc(8'h00, 8'hc1);
        wr(8'h00, 8'h00);
        rc(8'h00, 8'h00);
        chk(irq_ovf, 1'b0);
        // Edge PWM, high-true, value 0x10 in a 0x20 modulus, interrupt disabled
        wr(8'h20, 8'h28);
        wr(8'h24, 8'h00);
        wr(8'h28, 8'h10);
        wr(8'h00, 8'h01);
        repeat (40) @(negedge clk);
        pwm_high(33);
        chk(hi, 32'h10);
        rc(8'h20, 8'ha8);
        chk(irq_ch[0], 1'b0);
        // Center PWM: high from down match to up match
        wr(8'h00, 8'h21);
        repeat (70) @(negedge clk);
        pwm_high(64);
        chk(hi, 32'h20);
        end_of_test;
    end
endmodule : timer_pwm_unit_tb_top
